// [common/pwmcc_pkg.sv]
// Constants shared by the center-aligned, pair-capable PWM timer.
// Assumes a 32-bit APB register bus with byte addresses.
package pwmcc_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int unsigned NUM_CH     = 8;
    localparam int unsigned NUM_PAIRS  = 4;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned PRESC_W    = 3;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_CLKSEL   = 8'h08;
    localparam logic [7:0] OFS_ALIGN    = 8'h0c;
    localparam logic [7:0] OFS_PAIRING  = 8'h10;
    localparam logic [7:0] OFS_PRESCALE = 8'h14;
    localparam logic [7:0] OFS_COUNTER  = 8'h20;
    localparam logic [7:0] OFS_PERIOD   = 8'h40;
    localparam logic [7:0] OFS_DUTY     = 8'h60;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned PRESC_A_LSB = 0;
    localparam int unsigned PRESC_B_LSB = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE   = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;
    localparam logic [7:0] RST_CLKSEL   = 8'hcc;
    localparam logic [7:0] RST_ALIGN    = 8'h00;
    localparam logic [3:0] RST_PAIRING  = 4'h0;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_PERIOD   = 8'h00;
    localparam logic [7:0] RST_DUTY     = 8'h00;

    // ----------------------------------------------------------------
    // Register kinds
    // ----------------------------------------------------------------
    typedef enum {
        PWMCC_KIND_NONE,
        PWMCC_KIND_ENABLE,
        PWMCC_KIND_POLARITY,
        PWMCC_KIND_CLKSEL,
        PWMCC_KIND_ALIGN,
        PWMCC_KIND_PAIRING,
        PWMCC_KIND_PRESCALE,
        PWMCC_KIND_COUNTER,
        PWMCC_KIND_PERIOD,
        PWMCC_KIND_DUTY
    } pwmcc_kind_type;

endpackage : pwmcc_pkg

// [design/pwmcc_engine.sv]
// One PWM counter engine, 8 or 16 bits wide, left or center aligned.
// Assumes tick is a one-cycle enable at the selected channel clock rate.
module pwmcc_engine
    import pwmcc_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             enable,
    input  wire logic             center,
    input  wire logic             polarity,
    input  wire logic [CNT_W-1:0] period_buf,
    input  wire logic [CNT_W-1:0] duty_buf,
    input  wire logic             counter_wr,
    output logic                  level,
    output logic      [CNT_W-1:0] count
);

    logic             count_up;
    logic             phase;
    logic [CNT_W-1:0] period_act;
    logic [CNT_W-1:0] duty_act;
    logic [CNT_W-1:0] next_count;
    logic             next_up;
    logic             period_end;

    // ----------------------------------------------------------------
    // Counter sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_count = count;
        next_up    = count_up;
        period_end = 1'b0;
        if (period_act == '0) begin
            next_count = '0;
            period_end = 1'b1;
        end else if (center) begin
            if (count_up) begin
                if (count >= period_act) begin
                    next_up    = 1'b0;
                    next_count = count - 1'b1;
                end else begin
                    next_count = count + 1'b1;
                end
            end else begin
                next_count = count - 1'b1;
                if (next_count == '0) begin
                    next_up    = 1'b1;
                    period_end = 1'b1;
                end
            end
        end else begin
            next_up = 1'b1;
            if (count >= period_act - 1'b1) begin
                next_count = '0;
                period_end = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
        if (next_count == '0) begin
            next_up = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count    <= '0;
            count_up <= 1'b1;
        end else if (counter_wr) begin
            count    <= '0;
            count_up <= 1'b1;
        end else if (enable && tick) begin
            count    <= next_count;
            count_up <= next_up;
        end
    end

    // ----------------------------------------------------------------
    // Double-buffered compare values
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_act <= '0;
            duty_act   <= '0;
        end else if (!enable || counter_wr || (tick && period_end)) begin
            period_act <= period_buf;
            duty_act   <= duty_buf;
        end
    end

    // ----------------------------------------------------------------
    // Output flip-flop
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 1'b0;
        end else if (counter_wr) begin
            phase <= 1'b0;
        end else if (enable && tick) begin
            if (period_end && !center) begin
                phase <= 1'b0;
            end else if (next_count == duty_act && next_count != count) begin
                phase <= next_up ? 1'b1 : 1'b0;
            end else if (period_end) begin
                phase <= 1'b0;
            end
        end
    end

    // Phase low is the start of a cycle; polarity picks the start level.
    always_comb begin
        if (period_act == '0) begin
            level = polarity;
        end else if (duty_act == '0) begin
            level = ~polarity;
        end else if (duty_act >= period_act) begin
            level = polarity;
        end else begin
            level = polarity ? ~phase : phase;
        end
    end

endmodule : pwmcc_engine

// [design/pwmcc_timer.sv]
// Eight-channel PWM timer with center alignment and channel pairing,
// reached over APB.
// Assumes one clock pclk and an active-low asynchronous reset presetn.
module pwmcc_timer
    import pwmcc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [7:0]  channel_output_pin,
    output logic      [7:0]  channel_output_oe
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] channel_enable_bit;
    logic [7:0] polarity_reg;
    logic [7:0] channel_clock_sel;
    logic [7:0] alignment_select_reg;
    logic [3:0] pairing_control_reg;
    logic [7:0] prescale_reg;
    logic [7:0] period_value [NUM_CH];
    logic [7:0] duty_value   [NUM_CH];

    // ----------------------------------------------------------------
    // Decode and channel wiring
    // ----------------------------------------------------------------
    logic           wr_en;
    logic           setup_phase;
    pwmcc_kind_type acc_kind;
    logic [2:0]     acc_ch;
    logic [7:0]     counter_wr;
    logic [CNT_W-1:0] eng_count [NUM_CH];
    logic [7:0]     eng_level;
    logic [7:0]     eng_run;
    logic [7:0]     chan_tick;
    logic [7:0]     div_count;
    logic           tick_a;
    logic           tick_b;
    logic [31:0]    next_prdata;
    logic [7:0]     mask_a;
    logic [7:0]     mask_b;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic pwmcc_kind_type decode_kind(input logic [7:0] addr);
        pwmcc_kind_type k;
        k = PWMCC_KIND_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[7:5])
                OFS_COUNTER[7:5]: k = PWMCC_KIND_COUNTER;
                OFS_PERIOD[7:5]:  k = PWMCC_KIND_PERIOD;
                OFS_DUTY[7:5]:    k = PWMCC_KIND_DUTY;
                3'h0: begin
                    case (addr)
                        OFS_ENABLE:   k = PWMCC_KIND_ENABLE;
                        OFS_POLARITY: k = PWMCC_KIND_POLARITY;
                        OFS_CLKSEL:   k = PWMCC_KIND_CLKSEL;
                        OFS_ALIGN:    k = PWMCC_KIND_ALIGN;
                        OFS_PAIRING:  k = PWMCC_KIND_PAIRING;
                        OFS_PRESCALE: k = PWMCC_KIND_PRESCALE;
                        default:      k = PWMCC_KIND_NONE;
                    endcase
                end
                default: k = PWMCC_KIND_NONE;
            endcase
        end
        return k;
    endfunction : decode_kind

    // Mask of low divider bits that must all be set for a prescaled tick.
    function automatic logic [7:0] presc_mask(input logic [PRESC_W-1:0] sel);
        return 8'((9'h001 << sel) - 9'h001);
    endfunction : presc_mask

    assign acc_kind = decode_kind(paddr);
    assign acc_ch   = paddr[4:2];
    assign wr_en    = psel && penable && pready && pwrite;
    assign setup_phase = psel && !penable;

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_phase;
        end
    end

    // An unmapped or misaligned address is answered with an error, never a wait.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_phase && (acc_kind == PWMCC_KIND_NONE);
        end
    end

    // Read data is taken at setup so that it stands through the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    // In a pair the even counter register shows the upper byte of the odd engine.
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (acc_kind)
            PWMCC_KIND_ENABLE:   next_prdata[7:0] = channel_enable_bit;
            PWMCC_KIND_POLARITY: next_prdata[7:0] = polarity_reg;
            PWMCC_KIND_CLKSEL:   next_prdata[7:0] = channel_clock_sel;
            PWMCC_KIND_ALIGN:    next_prdata[7:0] = alignment_select_reg;
            PWMCC_KIND_PAIRING:  next_prdata[3:0] = pairing_control_reg;
            PWMCC_KIND_PRESCALE: next_prdata[7:0] = prescale_reg;
            PWMCC_KIND_PERIOD:   next_prdata[7:0] = period_value[acc_ch];
            PWMCC_KIND_DUTY:     next_prdata[7:0] = duty_value[acc_ch];
            PWMCC_KIND_COUNTER: begin
                if (!acc_ch[0] && pairing_control_reg[acc_ch[2:1]]) begin
                    next_prdata[7:0] = eng_count[acc_ch + 3'h1][15:8];
                end else begin
                    next_prdata[7:0] = eng_count[acc_ch][7:0];
                end
            end
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Each control register has its own write strobe from the address decode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_enable_bit <= RST_ENABLE;
        end else if (wr_en && acc_kind == PWMCC_KIND_ENABLE) begin
            channel_enable_bit <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polarity_reg <= RST_POLARITY;
        end else if (wr_en && acc_kind == PWMCC_KIND_POLARITY) begin
            polarity_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_clock_sel <= RST_CLKSEL;
        end else if (wr_en && acc_kind == PWMCC_KIND_CLKSEL) begin
            channel_clock_sel <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alignment_select_reg <= RST_ALIGN;
        end else if (wr_en && acc_kind == PWMCC_KIND_ALIGN) begin
            alignment_select_reg <= pwdata[7:0];
        end
    end

    // Pairing bits are meant to change only while both channels of a pair are stopped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pairing_control_reg <= RST_PAIRING;
        end else if (wr_en && acc_kind == PWMCC_KIND_PAIRING) begin
            pairing_control_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= RST_PRESCALE;
        end else if (wr_en && acc_kind == PWMCC_KIND_PRESCALE) begin
            prescale_reg <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Period and duty buffers
    // ----------------------------------------------------------------
    // The engines decide when a buffered value reaches their compare logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                period_value[i] <= RST_PERIOD;
            end
        end else if (wr_en && acc_kind == PWMCC_KIND_PERIOD) begin
            period_value[acc_ch] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                duty_value[i] <= RST_DUTY;
            end
        end else if (wr_en && acc_kind == PWMCC_KIND_DUTY) begin
            duty_value[acc_ch] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Channel clocks A and B
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    // Clock A and clock B tick whenever their low divider bits are all set.
    assign mask_a = presc_mask(prescale_reg[PRESC_A_LSB +: PRESC_W]);
    assign mask_b = presc_mask(prescale_reg[PRESC_B_LSB +: PRESC_W]);
    assign tick_a = (div_count & mask_a) == mask_a;
    assign tick_b = (div_count & mask_b) == mask_b;

    // ----------------------------------------------------------------
    // Channel engines
    // ----------------------------------------------------------------
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        localparam int unsigned HI = 2 * p;
        localparam int unsigned LO = 2 * p + 1;
        logic paired;
        assign paired = pairing_control_reg[p];

        // Even engine idles while paired; its enable bit is ignored.
        assign eng_run[HI] = channel_enable_bit[HI] && !paired;
        assign eng_run[LO] = channel_enable_bit[LO];

        assign chan_tick[HI] = channel_clock_sel[HI] ? tick_b : tick_a;
        assign chan_tick[LO] = channel_clock_sel[LO] ? tick_b : tick_a;

        assign counter_wr[HI] = wr_en && acc_kind == PWMCC_KIND_COUNTER
                                && acc_ch == 3'(HI);
        assign counter_wr[LO] = wr_en && acc_kind == PWMCC_KIND_COUNTER
                                && (acc_ch == 3'(LO) || (paired && acc_ch == 3'(HI)));

        pwmcc_engine u_hi (
            .pclk       (pclk),
            .presetn    (presetn),
            .tick       (chan_tick[HI]),
            .enable     (eng_run[HI]),
            .center     (alignment_select_reg[HI]),
            .polarity   (polarity_reg[HI]),
            .period_buf ({8'h00, period_value[HI]}),
            .duty_buf   ({8'h00, duty_value[HI]}),
            .counter_wr (counter_wr[HI]),
            .level      (eng_level[HI]),
            .count      (eng_count[HI])
        );

        // Odd engine runs 16 bits wide with the even channel as upper byte when paired.
        pwmcc_engine u_lo (
            .pclk       (pclk),
            .presetn    (presetn),
            .tick       (chan_tick[LO]),
            .enable     (eng_run[LO]),
            .center     (alignment_select_reg[LO]),
            .polarity   (polarity_reg[LO]),
            .period_buf ({paired ? period_value[HI] : 8'h00, period_value[LO]}),
            .duty_buf   ({paired ? duty_value[HI] : 8'h00, duty_value[LO]}),
            .counter_wr (counter_wr[LO]),
            .level      (eng_level[LO]),
            .count      (eng_count[LO])
        );

        // ------------------------------------------------------------
        // Output pins
        // ------------------------------------------------------------
        // Pins and enables are registered so that the pads never see decode glitches.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                channel_output_pin[HI] <= 1'b0;
                channel_output_pin[LO] <= 1'b0;
            end else begin
                channel_output_pin[HI] <= eng_run[HI] && eng_level[HI];
                channel_output_pin[LO] <= eng_run[LO] && eng_level[LO];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                channel_output_oe[HI] <= 1'b0;
                channel_output_oe[LO] <= 1'b0;
            end else begin
                channel_output_oe[HI] <= eng_run[HI];
                channel_output_oe[LO] <= eng_run[LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // No interrupt output exists on this block.

endmodule : pwmcc_timer

// [dv/pwmcc_timer_chk.sv]
// Concurrent checks on the APB port and the channel output pins of pwmcc_timer.
// Assumes it is bound to every instance of pwmcc_timer.
module pwmcc_timer_chk
    import pwmcc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  channel_output_pin,
    input wire logic [7:0]  channel_output_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;
    assign wr_done = psel && penable && pwrite && pready;

    // ----------------------------------------------------------------
    // Bus and pin relations
    // ----------------------------------------------------------------
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside one access cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_unmapped_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_quiet_after_reset: assert property ($rose(presetn) |-> channel_output_oe == 8'h00)
        else $error("output enabled right after reset");
    a_oe_from_write: assert property ($changed(channel_output_oe) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("output enable changed without a write");
    a_pin_off_undriven: assert property (($past(~channel_output_oe) & ~channel_output_oe & channel_output_pin) == 8'h00)
        else $error("pin active while not driven");
endmodule : pwmcc_timer_chk

bind pwmcc_timer pwmcc_timer_chk pwmcc_timer_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_output_pin(channel_output_pin), .channel_output_oe(channel_output_oe));

// [dv/pwmcc_timer_bench.sv]
// Self-checking bench for pwmcc_timer: APB register tasks and waveform measurement.
// Assumes prescale 0, one count per pclk, except where a test slows clock B.
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module pwmcc_timer_bench
    import pwmcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, pin, oe;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    int err_count = 0, num_checks = 0, cyc = 0, hi, edges;
    int tab [8][4] = '{'{4,0,1,0}, '{4,0,0,16}, '{0,2,1,16}, '{0,2,0,0},
                       '{4,5,1,16}, '{4,5,0,0}, '{4,1,0,12}, '{4,1,1,4}};

    pwmcc_timer pwmcc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channel_output_pin(pin), .channel_output_oe(oe));

    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic measure(input int ch, input int n);
        logic prev;
        repeat (24) @(negedge pclk);
        prev = pin[ch];
        hi = 0;
        edges = 0;
        repeat (n) begin
            @(negedge pclk);
            hi += int'(pin[ch]);
            edges += int'(pin[ch] != prev);
            prev = pin[ch];
        end
    endtask : measure

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_CLKSEL, 0);   `CHK("clksel", RST_CLKSEL, rd[7:0])
        apb(0, OFS_ENABLE, 0);   `CHK("enable", RST_ENABLE, rd[7:0])
        apb(0, OFS_ALIGN, 0);    `CHK("align", RST_ALIGN, rd[7:0])
        apb(0, 8'h18, 0);        `CHK("unmapped", 33'h100000000, {er, rd})
        for (int ch = 0; ch < 8; ch++) begin
            apb(1, OFS_ENABLE, 0);
            apb(1, OFS_POLARITY, 32'(tab[ch][2]) << ch);
            apb(1, OFS_ALIGN, 32'h1 << ch);
            apb(1, OFS_PERIOD + 8'(4 * ch), 32'(tab[ch][0]));
            apb(1, OFS_DUTY + 8'(4 * ch), 32'(tab[ch][1]));
            apb(1, OFS_COUNTER + 8'(4 * ch), 0);
            apb(1, OFS_ENABLE, 32'h1 << ch);
            measure(ch, 16);
            `CHK("oe", 8'(1 << ch), oe)
            `CHK("high", tab[ch][3], hi)
            `CHK("edges", (tab[ch][3] % 16 == 0) ? 0 : 4, edges)
        end
        apb(1, OFS_ENABLE, 0);
        apb(1, OFS_ALIGN, 0);
        apb(1, OFS_PRESCALE, 32'h10);
        apb(1, OFS_COUNTER + 8'h18, 0);
        apb(1, OFS_ENABLE, 32'h40);
        measure(6, 16);
        `CHK("left high", 12, hi)
        `CHK("left edges", 4, edges)
        apb(1, OFS_ENABLE, 0);
        apb(1, OFS_PRESCALE, 0);
        apb(1, OFS_PAIRING, 32'h2);
        apb(1, OFS_POLARITY, 32'h8);
        apb(1, OFS_ALIGN, 32'h8);
        apb(1, OFS_PERIOD + 8'h08, 32'h1);
        apb(1, OFS_PERIOD + 8'h0c, 32'h0);
        apb(1, OFS_DUTY + 8'h08, 32'h0);
        apb(1, OFS_DUTY + 8'h0c, 32'h40);
        apb(1, OFS_COUNTER + 8'h0c, 0);
        apb(1, OFS_ENABLE, 32'h4);
        repeat (4) @(negedge pclk);
        `CHK("even enable", 8'h00, oe)
        apb(1, OFS_ENABLE, 32'hc);
        measure(3, 512);
        `CHK("pair oe", 8'h08, oe)
        `CHK("pair high", 128, hi)
        `CHK("pair edges", 2, edges)
        apb(1, OFS_COUNTER + 8'h08, 0);
        apb(0, OFS_COUNTER + 8'h08, 0);  `CHK("cnt hi", 8'h00, rd[7:0])
        apb(0, OFS_COUNTER + 8'h0c, 0);  `CHK("cnt lo", 1'b1, rd[7:0] < 8'h08)
        wrap_up();
    end
endmodule : pwmcc_timer_bench
